// File: src/fas_pkg.sv
// package for the flash command sequencer: constants, states and carriers
// assumes a 10 MHz system clock and a simple synchronous memory bus
package fas_pkg;
    // bus shape
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int ARR_AW = 16; // word index width of the modelled array
    // command addresses (low twelve bits) and codes
    localparam logic [11:0] UNLOCK1_ADDR = 12'haaa;
    localparam logic [11:0] UNLOCK2_ADDR = 12'h554;
    localparam logic [11:0] PROT_ADDR = 12'h77e;
    localparam logic [11:0] ADDR_LOW_MASK = 12'hfff;
    localparam logic [7:0] UNLOCK1_DATA = 8'haa;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
    localparam logic [7:0] CMD_PROTECT = 8'ha5;
    localparam logic [7:0] PROT_READ_DATA = 8'hf0;
    localparam logic [7:0] PROT_WRITE_DATA = 8'h0f;
    // erased value
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // status bit positions
    localparam int DATA_POLLING_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    // identification locations (low address bits) and read data
    localparam logic [11:0] ID_VENDOR_ADDR = 12'h000;
    localparam logic [11:0] ID_MACRO_ADDR = 12'h002;
    localparam logic [11:0] ID_SIZE_ADDR = 12'h004;
    localparam logic [15:0] VENDOR_CODE = 16'h005a; // arbitrary value
    localparam logic [15:0] MACRO_CODE = 16'h00a5; // arbitrary value
    localparam logic [15:0] SIZE_CODE = 16'h0011; // arbitrary value
    localparam int PROT_RD_POS = 0; // read protect bit in status word
    localparam int PROT_WR_POS = 1; // write protect bit in status word
    // sector select: address bits 23..12
    localparam int SECT_HI = 23;
    localparam int SECT_LO = 12;
    // timing, then cycles at 10 MHz
    localparam longint CLK_HZ = 64'd10000000;
    localparam longint CHIP_ERASE_MS = 64'd300;
    localparam longint SECTOR_ERASE_MS = 64'd75;
    localparam longint PROTECT_US = 64'd60;
    localparam longint PROGRAM_US = 64'd60;
    localparam longint SETTLE_US = 64'd1;
    localparam longint CHIP_ERASE_CYC = CHIP_ERASE_MS * CLK_HZ / 64'd1000;
    localparam longint SECTOR_ERASE_CYC = SECTOR_ERASE_MS * CLK_HZ / 64'd1000;
    localparam longint PROTECT_CYC = PROTECT_US * CLK_HZ / 64'd1000000;
    localparam longint PROGRAM_CYC = PROGRAM_US * CLK_HZ / 64'd1000000;
    localparam longint SETTLE_CYC = (SETTLE_US * CLK_HZ + 64'd999999) / 64'd1000000;
    localparam int CNT_W = 32;
    // command decoder states, one-hot
    typedef enum logic [5:0] {
        CS_IDLE = 6'b000001,
        CS_UNL1 = 6'b000010,
        CS_UNL2 = 6'b000100,
        CS_ERS = 6'b001000,
        CS_ERS1 = 6'b010000,
        CS_ERS2 = 6'b100000
    } fas_cmd_t;
    // automatic operation kinds, one-hot
    typedef enum logic [5:0] {
        OP_NONE = 6'b000001,
        OP_PROG = 6'b000010,
        OP_SECT = 6'b000100,
        OP_CHIP = 6'b001000,
        OP_PROT = 6'b010000,
        OP_SETL = 6'b100000
    } fas_op_t;
    // cpu bus request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fas_req_t;
    // array port request
    typedef struct packed {
        logic we;
        logic [ARR_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fas_mem_t;
endpackage

// File: src/fas_array.sv
// flash array storage with registered read data
// assumes one access per clock; the sequencer drives erase sweeps
`timescale 1ns/1ps
module fas_array #(
    parameter int AW = 16,
    parameter int DW = 16
) (
    input wire logic MCLK,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    // cells, no reset: non-volatile
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // write, and registered read of the word held before the write
    always_ff @(posedge MCLK) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// File: src/fas_timer.sv
// down counter timing one automatic operation
// assumes load and count come from the sequencer's domain
`timescale 1ns/1ps
module fas_timer #(
    parameter int W = 32
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
        logic done;
    } fas_tmr_t;
    fas_tmr_t s_q, s_d;

    // count down; done pulses one cycle at the end
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (load) begin
            s_d.cnt = count;
            s_d.run = 1'b1;
        end else if (s_q.run) begin
            if (s_q.cnt <= W'(1)) begin
                s_d.run = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign done = s_q.done;
endmodule

// File: src/fas_seq.sv
// flash command sequencer: command decode, automatic operations, status reads
// assumes the cpu issues one read or write per cycle on a synchronous bus
`timescale 1ns/1ps
// How it works
// [R1] chip erase clears whole array, 300 ms
// [R2] no new command while operation runs
// [R3] erased words read all ones
// [R4] id entry returns codes and protection
// [R5] id mode hides array contents
// [R6] id exit returns to array reads
// [R7] read protect blocks programmer reads, transfer
// [R8] write protect blocks programmer writes, transfer
// [R9] only chip erase clears protection flags
// [R10] protection status at low address 77e
// [R11] protect set finishes within 60 us
// [R12] program: bit 7 inverted until done
// [R13] erase: bit 7 zero, settle 1 us
// [R14] software uses toggle for protect polling
// [R15] bit 6 toggles per read while busy
// [R16] first toggle read returns one
// [R17] software imposes own polling time limits
// [R18] array reads need no command
// [R19] software runs routines outside flash
// [R20] software disables interrupts while programming
// [R21] software polls until reads match
// [R22] serial boot maps rom over vectors
// [R23] program address even, fourth write
// [R24] sector from address bits 23..12; the code keeps only bits 16..12 of them
// [R25] software programs zero for protect
// [R26] sector erase within 75 ms
// [R27] unlock pair then command, else idle
// [R28] protection flags survive reset
module fas_seq #(
    parameter int AW = fas_pkg::ARR_AW,
    parameter longint CHIP_CYC = fas_pkg::CHIP_ERASE_CYC,
    parameter longint SECT_CYC = fas_pkg::SECTOR_ERASE_CYC,
    parameter longint PROT_CYC = fas_pkg::PROTECT_CYC,
    parameter longint PROG_CYC = fas_pkg::PROGRAM_CYC
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire fas_pkg::fas_req_t REQ,
    input wire logic PROGRAMMER_MODE,
    input wire logic SERIAL_BOOT,
    input wire logic RAM_XFER_REQ,
    input wire logic PROT_RD_NV,
    input wire logic PROT_WR_NV,
    output logic [fas_pkg::DATA_W-1:0] RDATA,
    output logic RVALID,
    output logic BUSY,
    output logic ID_MODE,
    output logic PROT_RD,
    output logic PROT_WR,
    output logic PROT_NV_WE,
    output logic RAM_XFER_OK,
    output logic RAM_XFER_REFUSED,
    output logic BOOT_ROM_MAP
);
    import fas_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fas_cmd_t cmd; // command decoder state
        fas_op_t op; // running automatic operation
        logic id_mode; // identification mode
        logic tog; // toggle bit value of the next read
        logic prot_rd; // read protection flag
        logic prot_wr; // write protection flag
        logic nv_we; // pulse: flags written to cells
        logic strap; // flags caught from cells after reset
        logic [DATA_W-1:0] pdata; // word being programmed
        logic [AW-1:0] paddr; // word address being programmed
        logic [AW-1:0] sweep; // erase sweep pointer
        logic [AW-1:0] s_lo; // sweep first word
        logic [AW-1:0] s_hi; // sweep last word
        logic sweep_on; // erase sweep in progress
        logic rd_pend; // registered read waiting for data
        logic rd_stat; // pending read returns status
        logic [DATA_W-1:0] rd_fix; // fixed data for id/blocked read
        logic rd_use_fix; // pending read uses rd_fix
        logic [DATA_W-1:0] rdata; // read data output
        logic rvalid; // read data valid
        logic xfer_ok; // transfer accepted
        logic xfer_ref; // transfer refused
        logic boot_map; // boot rom mapped over vectors
    } fas_st_t;
    fas_st_t s_q, s_d;

    // array and timer wiring
    logic [DATA_W-1:0] arr_rdata;
    fas_mem_t mreq;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic tmr_done;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [11:0] alow;
    logic [7:0] wlow;
    logic busy;
    logic [AW-1:0] widx;
    assign alow = REQ.addr[11:0] & ADDR_LOW_MASK;
    assign wlow = REQ.wdata[7:0];
    assign busy = (s_q.op != OP_NONE);
    assign widx = REQ.addr[AW:1]; // word index from byte address

    // sector first word from address bits 16..12 (bits 23..17 fall outside the word index)
    function automatic logic [AW-1:0] sect_base(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] b;
        b = '0;
        b[SECT_HI:SECT_LO] = a[SECT_HI:SECT_LO];
        return b[AW:1];
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.nv_we = 1'b0;
        s_d.rvalid = 1'b0;
        s_d.xfer_ok = 1'b0;
        s_d.xfer_ref = 1'b0;
        mreq = '0;
        tmr_load = 1'b0;
        tmr_count = '0;
        // catch stored flags after reset
        if (!s_q.strap) begin
            s_d.strap = 1'b1;
            s_d.prot_rd = PROT_RD_NV; // R28
            s_d.prot_wr = PROT_WR_NV; // R28
        end
        s_d.boot_map = SERIAL_BOOT; // R22
        // ram transfer command from serial boot loader
        if (SERIAL_BOOT && RAM_XFER_REQ) begin
            if (s_q.prot_rd || s_q.prot_wr) begin
                s_d.xfer_ref = 1'b1; // R7 R8
            end else begin
                s_d.xfer_ok = 1'b1;
            end
        end
        // deliver pending read
        if (s_q.rd_pend) begin
            s_d.rd_pend = 1'b0;
            s_d.rvalid = 1'b1;
            if (s_q.rd_use_fix) begin
                s_d.rdata = s_q.rd_fix;
            end else if (s_q.rd_stat) begin
                s_d.rdata = '0;
                s_d.rdata[TOGGLE_BIT] = s_q.tog; // R15
                s_d.tog = ~s_q.tog; // R15
                unique case (s_q.op)
                    OP_PROG: s_d.rdata[DATA_POLLING_BIT] = ~s_q.pdata[DATA_POLLING_BIT]; // R12
                    OP_SECT, OP_CHIP: s_d.rdata[DATA_POLLING_BIT] = 1'b0; // R13
                    OP_SETL: s_d.rdata[DATA_POLLING_BIT] = 1'b1; // R13
                    default: s_d.rdata[DATA_POLLING_BIT] = 1'b0; // protect set: not usable
                endcase
            end else begin
                s_d.rdata = arr_rdata; // R18
            end
        end
        // bus reads
        if (REQ.rd) begin
            s_d.rd_pend = 1'b1;
            s_d.rd_stat = busy; // R2
            s_d.rd_use_fix = 1'b0;
            mreq.addr = widx;
            if (!busy && s_q.id_mode) begin
                s_d.rd_use_fix = 1'b1; // R5
                s_d.rd_fix = '0;
                if (alow == PROT_ADDR) begin
                    s_d.rd_fix[PROT_RD_POS] = s_q.prot_rd; // R10
                    s_d.rd_fix[PROT_WR_POS] = s_q.prot_wr; // R10
                end else if (alow == ID_VENDOR_ADDR) begin
                    s_d.rd_fix = VENDOR_CODE; // R4
                end else if (alow == ID_MACRO_ADDR) begin
                    s_d.rd_fix = MACRO_CODE; // R4
                end else if (alow == ID_SIZE_ADDR) begin
                    s_d.rd_fix = SIZE_CODE; // R4
                end
            end else if (!busy && PROGRAMMER_MODE && s_q.prot_rd) begin
                s_d.rd_use_fix = 1'b1; // R7
                s_d.rd_fix = '0;
            end
        end
        // bus writes: command decoder, ignored while busy
        if (REQ.wr && !busy) begin // R2
            s_d.cmd = CS_IDLE; // R27
            unique case (s_q.cmd)
                CS_IDLE: begin
                    if (s_q.id_mode && wlow == CMD_ID_EXIT) begin
                        s_d.id_mode = 1'b0; // R6
                    end else if (alow == UNLOCK1_ADDR && wlow == UNLOCK1_DATA) begin
                        s_d.cmd = CS_UNL1; // R27
                    end
                end
                CS_UNL1: begin
                    if (alow == UNLOCK2_ADDR && wlow == UNLOCK2_DATA) begin
                        s_d.cmd = CS_UNL2; // R27
                    end
                end
                CS_UNL2: begin
                    if (alow == UNLOCK1_ADDR) begin
                        if (wlow == CMD_ERASE_SETUP) begin
                            s_d.cmd = CS_ERS;
                        end else if (wlow == CMD_ID_ENTRY) begin
                            s_d.id_mode = 1'b1; // R4
                        end else if (wlow == CMD_ID_EXIT) begin
                            s_d.id_mode = 1'b0; // R6
                        end else if (wlow == CMD_PROGRAM) begin
                            s_d.cmd = CS_ERS2; // next write is the program word
                            s_d.s_hi = '0; // program path
                        end else if (wlow == CMD_PROTECT) begin
                            s_d.cmd = CS_ERS1; // next write selects protect kind
                        end
                    end
                end
                CS_ERS: begin
                    if (alow == UNLOCK1_ADDR && wlow == UNLOCK1_DATA) begin
                        s_d.cmd = CS_ERS1;
                        s_d.s_hi = {{(AW-1){1'b0}}, 1'b1}; // marks erase path
                    end
                end
                CS_ERS1: begin
                    if (s_q.s_hi == {{(AW-1){1'b0}}, 1'b1}) begin
                        // erase path: second unlock
                        if (alow == UNLOCK2_ADDR && wlow == UNLOCK2_DATA) begin
                            s_d.cmd = CS_ERS2;
                        end
                    end else if (alow == PROT_ADDR) begin
                        // protect set path
                        s_d.op = OP_PROT;
                        tmr_load = 1'b1;
                        tmr_count = CNT_W'(PROT_CYC); // R11
                        s_d.tog = 1'b1; // R16
                        if (wlow == PROT_READ_DATA) begin
                            s_d.prot_rd = 1'b1;
                        end else if (wlow == PROT_WRITE_DATA) begin
                            s_d.prot_wr = 1'b1;
                        end
                        s_d.nv_we = 1'b1;
                    end
                end
                CS_ERS2: begin
                    if (s_q.s_hi == {{(AW-1){1'b0}}, 1'b1}) begin
                        if (wlow == CMD_CHIP_ERASE && alow == UNLOCK1_ADDR) begin
                            s_d.op = OP_CHIP; // R1
                            s_d.sweep = '0;
                            s_d.s_hi = '1;
                            s_d.sweep_on = 1'b1;
                            tmr_load = 1'b1;
                            tmr_count = CNT_W'(CHIP_CYC); // R1
                            s_d.tog = 1'b1; // R16
                        end else if (wlow == CMD_SECTOR_ERASE) begin
                            s_d.op = OP_SECT; // R26
                            s_d.sweep = sect_base(REQ.addr); // R24
                            s_d.s_hi = sect_base(REQ.addr) + AW'((1 << (SECT_LO - 1)) - 1); // R24
                            s_d.sweep_on = 1'b1;
                            tmr_load = 1'b1;
                            tmr_count = CNT_W'(SECT_CYC); // R26
                            s_d.tog = 1'b1; // R16
                        end
                    end else if (!(PROGRAMMER_MODE && s_q.prot_wr)) begin // R8
                        s_d.op = OP_PROG; // R12
                        s_d.paddr = widx;
                        s_d.pdata = REQ.wdata;
                        mreq.we = 1'b1;
                        mreq.addr = widx;
                        mreq.wdata = REQ.wdata;
                        tmr_load = 1'b1;
                        tmr_count = CNT_W'(PROG_CYC);
                        s_d.tog = 1'b1; // R16
                    end
                end
                default: s_d.cmd = CS_IDLE;
            endcase
        end
        // erase sweep writes all ones, one word per cycle
        if (s_q.sweep_on) begin
            mreq.we = 1'b1;
            mreq.addr = s_q.sweep;
            mreq.wdata = ERASED_WORD; // R3
            s_d.sweep = s_q.sweep + AW'(1);
            if (s_q.sweep == s_q.s_hi) begin
                s_d.sweep_on = 1'b0;
            end
        end
        // operation end
        if (tmr_done) begin
            if (s_q.op == OP_CHIP) begin
                s_d.prot_rd = 1'b0; // R9
                s_d.prot_wr = 1'b0; // R9
                s_d.nv_we = 1'b1;
            end
            if (s_q.op == OP_SECT || s_q.op == OP_CHIP) begin
                s_d.op = OP_SETL; // R13
                tmr_load = 1'b1;
                tmr_count = CNT_W'(SETTLE_CYC); // R13
            end else begin
                s_d.op = OP_NONE;
            end
            s_d.s_hi = '0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            s_q <= '0;
            s_q.cmd <= CS_IDLE;
            s_q.op <= OP_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // array and timer
    // ------------------------------------------------------------
    fas_array #(.AW(AW), .DW(DATA_W)) u_array (
        .MCLK(MCLK),
        .we(mreq.we),
        .addr(mreq.addr),
        .wdata(mreq.wdata),
        .rdata(arr_rdata)
    );

    fas_timer #(.W(CNT_W)) u_timer (
        .MCLK(MCLK),
        .RSTN(RSTN),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // outputs straight from state flops, except BUSY, which is decoded from the op field
    assign RDATA = s_q.rdata;
    assign RVALID = s_q.rvalid;
    assign BUSY = (s_q.op != OP_NONE);
    assign ID_MODE = s_q.id_mode;
    assign PROT_RD = s_q.prot_rd;
    assign PROT_WR = s_q.prot_wr;
    assign PROT_NV_WE = s_q.nv_we;
    assign RAM_XFER_OK = s_q.xfer_ok;
    assign RAM_XFER_REFUSED = s_q.xfer_ref;
    assign BOOT_ROM_MAP = s_q.boot_map;
endmodule

// File: tb/fas_seq_props.sv
// port checker for the flash command sequencer
// assumes one clock MCLK and async active-low RSTN
`timescale 1ns/1ps
module fas_seq_props #(
    parameter longint CHIP_CYC = 65536
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire fas_pkg::fas_req_t REQ,
    input wire logic PROGRAMMER_MODE,
    input wire logic SERIAL_BOOT,
    input wire logic RAM_XFER_REQ,
    input wire logic PROT_RD_NV,
    input wire logic PROT_WR_NV,
    input wire logic [fas_pkg::DATA_W-1:0] RDATA,
    input wire logic RVALID,
    input wire logic BUSY,
    input wire logic ID_MODE,
    input wire logic PROT_RD,
    input wire logic PROT_WR,
    input wire logic PROT_NV_WE,
    input wire logic RAM_XFER_OK,
    input wire logic RAM_XFER_REFUSED,
    input wire logic BOOT_ROM_MAP
);
    import fas_pkg::*;
    logic [31:0] busy_q; // length of the current busy stretch
    // count busy cycles, clear when idle
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            busy_q <= 32'h0;
        end else begin
            busy_q <= BUSY ? busy_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    chk_read_answer: assert property (REQ.rd |-> ##2 RVALID)
        else $error("read not answered");
    chk_read_cause: assert property (RVALID |-> $past(REQ.rd, 2))
        else $error("stray read answer");
    chk_xfer_block: assert property (RAM_XFER_REQ && SERIAL_BOOT && (PROT_RD || PROT_WR)
        |=> RAM_XFER_REFUSED && !RAM_XFER_OK) else $error("transfer not refused");
    chk_xfer_allow: assert property (RAM_XFER_REQ && SERIAL_BOOT && !PROT_RD && !PROT_WR
        |=> RAM_XFER_OK) else $error("transfer not granted");
    chk_id_cause: assert property ($changed(ID_MODE) |-> $past(REQ.wr) || $past(REQ.wr, 2))
        else $error("id mode moved alone");
    chk_id_busy: assert property ($rose(ID_MODE) |-> !$past(BUSY))
        else $error("command taken while busy");
    chk_busy_cause: assert property ($rose(BUSY) |-> $past(REQ.wr) || $past(REQ.wr, 2))
        else $error("operation started without a write");
    chk_flag_clear: assert property ($fell(PROT_RD) || $fell(PROT_WR) |-> $past(BUSY) || $past(BUSY, 2))
        else $error("protection dropped early");
    chk_busy_bound: assert property (busy_q <= CHIP_CYC + 32)
        else $error("operation overran its limit");
    cover property ($rose(BUSY));
    cover property ($rose(ID_MODE));
    cover property (RAM_XFER_REFUSED);
endmodule
bind fas_seq fas_seq_props #(.CHIP_CYC(CHIP_CYC)) u_fas_seq_props (.*);

// File: tb/fas_cpu.sv
// cpu bus model: command writes and polling reads
// assumes bus moves at falling MCLK edges
`timescale 1ns/1ps
module fas_cpu (
    input wire logic MCLK,
    input wire logic [15:0] RDATA,
    input wire logic RVALID,
    output fas_pkg::fas_req_t REQ
);
    import fas_pkg::*;
    // routines run from ram with interrupts off, so no fetch hits the array
    initial REQ = '0;
    // one write, held for one clock
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(negedge MCLK);
        REQ <= '{1'b0, 1'b1, a, d};
        @(negedge MCLK);
        REQ <= '0;
    endtask
    // one read, answer taken in a bounded wait
    task automatic rd(input logic [23:0] a, output logic [15:0] d);
        d = 16'h0;
        @(negedge MCLK);
        REQ <= '{1'b1, 1'b0, a, 16'h0};
        @(negedge MCLK);
        REQ <= '0;
        repeat (3) begin
            @(negedge MCLK);
            if (RVALID === 1'b1) begin
                d = RDATA;
            end
        end
    endtask
    // reread until two reads match, at most lim tries
    task automatic poll(input logic [23:0] a, input int lim, output logic [15:0] d);
        logic [15:0] p;
        rd(a, p);
        for (int i = 0; i < lim; i++) begin
            rd(a, d);
            if (d === p) break;
            p = d;
        end
    endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the flash command sequencer
// assumes fas_cpu drives the bus; a cell model holds the flags
`timescale 1ns/1ps
module testbench;
    import fas_pkg::*;
    typedef struct packed {logic [23:0] a; logic [15:0] v;} fas_row_t;
    logic MCLK, RSTN, pmode, sboot, xreq, nv_rd, nv_wr;
    logic rvalid, busy, id_mode, prot_rd, prot_wr, nv_we, x_ok, x_ref, rom_map;
    logic [15:0] rdata, d;
    fas_req_t req;
    int err_total, total_checks;
    fas_row_t rows [3] = '{'{24'h000000, 16'h0706}, '{24'h01fffe, 16'h8001}, '{24'h000ffe, 16'h7f80}};
    fas_seq #(.CHIP_CYC(65536), .SECT_CYC(4096), .PROT_CYC(50), .PROG_CYC(50)) u_fas_seq (.MCLK(MCLK),
        .RSTN(RSTN), .REQ(req), .PROGRAMMER_MODE(pmode), .SERIAL_BOOT(sboot), .RAM_XFER_REQ(xreq),
        .PROT_RD_NV(nv_rd), .PROT_WR_NV(nv_wr), .RDATA(rdata), .RVALID(rvalid), .BUSY(busy),
        .ID_MODE(id_mode), .PROT_RD(prot_rd), .PROT_WR(prot_wr), .PROT_NV_WE(nv_we),
        .RAM_XFER_OK(x_ok), .RAM_XFER_REFUSED(x_ref), .BOOT_ROM_MAP(rom_map));
    fas_cpu u_fas_cpu (.MCLK(MCLK), .RDATA(rdata), .RVALID(rvalid), .REQ(req));
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    // stored protection cells follow the write strobe
    always @(negedge MCLK) begin
        if (nv_we === 1'b1) begin
            nv_rd <= prot_rd;
            nv_wr <= prot_wr;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rst();
        @(negedge MCLK);
        RSTN <= 1'b0;
        repeat (5) @(negedge MCLK);
        RSTN <= 1'b1;
        repeat (3) @(negedge MCLK);
    endtask
    // unlock pair then a command code
    task automatic cmd(input logic [7:0] c);
        u_fas_cpu.wr(24'h000aaa, 16'h00aa);
        u_fas_cpu.wr(24'h000554, 16'h0055);
        u_fas_cpu.wr(24'h000aaa, {8'h0, c});
        @(negedge MCLK);
    endtask
    task automatic xfer();
        @(negedge MCLK);
        xreq <= 1'b1;
        @(negedge MCLK);
        xreq <= 1'b0;
    endtask
    initial begin
        #10_000_000;
        err_total++;
        close_out();
    end
    initial begin
        {RSTN, pmode, sboot, xreq, nv_rd, nv_wr} = 6'h0;
        err_total = 0;
        total_checks = 0;
        rst();
        cmd(CMD_PROTECT);
        u_fas_cpu.wr(24'h00077e, {8'h0, PROT_WRITE_DATA});
        u_fas_cpu.rd(24'h00077e, d);
        chk({15'h0, d[TOGGLE_BIT]}, 16'h1);
        u_fas_cpu.rd(24'h00077e, d);
        chk({15'h0, d[TOGGLE_BIT]}, 16'h0);
        u_fas_cpu.poll(24'h00077e, 40, d);
        chk({15'h0, busy}, 16'h0);
        sboot <= 1'b1;
        xfer();
        chk({14'h0, x_ref, x_ok}, 16'h2);
        chk({15'h0, rom_map}, 16'h1);
        cmd(CMD_PROTECT);
        u_fas_cpu.wr(24'h00077e, {8'h0, PROT_READ_DATA});
        u_fas_cpu.poll(24'h00077e, 40, d);
        pmode <= 1'b1;
        u_fas_cpu.rd(24'h000100, d);
        chk(d, 16'h0);
        pmode <= 1'b0;
        rst();
        chk({14'h0, prot_wr, prot_rd}, 16'h3);
        cmd(CMD_ID_ENTRY);
        chk({15'h0, id_mode}, 16'h1);
        u_fas_cpu.rd(24'h00077e, d);
        chk(d, 16'h3);
        u_fas_cpu.rd(24'h000000, d);
        chk(d, VENDOR_CODE);
        u_fas_cpu.wr(24'h000000, 16'h00f0);
        @(negedge MCLK);
        chk({15'h0, id_mode}, 16'h0);
        cmd(CMD_ERASE_SETUP);
        cmd(CMD_CHIP_ERASE);
        u_fas_cpu.rd(24'h000000, d);
        chk({14'h0, d[DATA_POLLING_BIT], d[TOGGLE_BIT]}, 16'h1);
        u_fas_cpu.rd(24'h000000, d);
        chk({15'h0, d[TOGGLE_BIT]}, 16'h0);
        u_fas_cpu.poll(24'h000000, 20000, d);
        chk(d, ERASED_WORD);
        chk({14'h0, prot_wr, prot_rd}, 16'h0);
        foreach (rows[i]) begin
            u_fas_cpu.rd(rows[i].a, d);
            chk(d, ERASED_WORD);
            cmd(CMD_PROGRAM);
            u_fas_cpu.wr(rows[i].a, rows[i].v);
            u_fas_cpu.rd(rows[i].a, d);
            chk({15'h0, d[DATA_POLLING_BIT]}, {15'h0, ~rows[i].v[7]});
            u_fas_cpu.poll(rows[i].a, 40, d);
            chk(d, rows[i].v);
        end
        u_fas_cpu.wr(24'h000aaa, 16'h00aa);
        u_fas_cpu.wr(24'h000554, 16'h0000);
        u_fas_cpu.wr(24'h000aaa, {8'h0, CMD_ID_ENTRY});
        chk({15'h0, id_mode}, 16'h0);
        cmd(CMD_PROGRAM);
        u_fas_cpu.wr(24'h000200, 16'h1234);
        cmd(CMD_ID_ENTRY);
        chk({15'h0, id_mode}, 16'h0);
        u_fas_cpu.poll(24'h000200, 40, d);
        cmd(CMD_ERASE_SETUP);
        cmd(CMD_SECTOR_ERASE);
        u_fas_cpu.poll(24'h000000, 2000, d);
        chk(d, ERASED_WORD);
        cmd(CMD_ID_ENTRY);
        u_fas_cpu.rd(rows[1].a, d);
        chk(d, 16'h0);
        cmd(CMD_ID_EXIT);
        u_fas_cpu.rd(rows[1].a, d);
        chk(d, rows[1].v);
        xfer();
        chk({14'h0, x_ref, x_ok}, 16'h1);
        close_out();
    end
endmodule
